//--- nand_host_pkg.sv
// constants shared by the byte-wide nand flash host controller
// assumes a 100 MHz system clock
package nand_host_pkg;
  localparam int unsigned clock_period_ns = 10;
  localparam int unsigned powerup_wait_ns = 1000;
  localparam int unsigned powerup_cycles = (powerup_wait_ns + clock_period_ns - 1) / clock_period_ns;
  localparam int unsigned strobe_cycles = 3;
  localparam logic [7:0] cmd_read_first_half = 8'h00;
  localparam logic [7:0] cmd_read_second_half = 8'h01;
  localparam logic [7:0] cmd_program_setup = 8'h80;
  localparam logic [7:0] cmd_program_confirm = 8'h10;
  localparam logic [7:0] cmd_erase_setup = 8'h60;
  localparam logic [7:0] cmd_erase_confirm = 8'hd0;
  localparam int unsigned row_hi_bits = 2;
  localparam int unsigned page_bytes = 528;
endpackage

//--- nand_host.sv
// host controller driving a byte-wide nand flash over its multiplexed port
// assumes the flash pins are asynchronous to clock; io is split in/out/enable
//
// Behaviour
// - command, address and data share one 8-bit port, qualified by latch pins
// - four address cycles (erase: three, no column): column, row bits 9-16, 17-24, then 25-26 low bits
// - fourth address cycle drives all io bits above the two row bits low
// - host waits at least 1us after power-up before any command
// - bytes driven with chip enable low, latched on write strobe rise
`timescale 1ns/1ns
module nand_host
  import nand_host_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic req_valid,
  input wire logic [1:0] req_op,
  input wire logic req_second_half,
  input wire logic [26:0] req_addr,
  output logic req_ready,
  input wire logic [7:0] wr_data,
  output logic wr_take,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic chip_enable_n,
  output logic cmd_latch,
  output logic addr_latch,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic write_protect_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_n
);
  // req_op: 0 read, 1 program, 2 erase
  typedef enum logic [7:0] {
    st_power = 8'h01, st_idle = 8'h02, st_cmd = 8'h04, st_addr = 8'h08,
    st_wbusy = 8'h10, st_data = 8'h20, st_conf = 8'h40, st_read = 8'h80
  } state_t;

  state_t state_reg;
  logic [10:0] wait_reg;
  logic [2:0] sub_reg;
  logic [2:0] acnt_reg;
  logic [9:0] bcnt_reg;
  logic [1:0] op_reg;
  logic half_reg;
  logic [26:0] addr_reg;
  logic [2:0] rb_sync_reg;
  logic rb_reg;

  // --------------------------------------------------------------------
  // ready/busy synchroniser
  // --------------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rb_sync_reg <= 3'h0;
      rb_reg <= 1'b0;
    end else begin
      rb_sync_reg <= {rb_sync_reg[1:0], ready_busy_n};
      if (rb_sync_reg[2] == rb_sync_reg[1]) begin
        rb_reg <= rb_sync_reg[2];
      end
    end
  end

  function automatic logic [7:0] addr_byte(input logic [2:0] idx, input logic [26:0] a);
    case (idx)
      3'h0: addr_byte = a[7:0];
      3'h1: addr_byte = a[16:9];
      3'h2: addr_byte = a[24:17];
      default: addr_byte = {6'h00, a[26:25]};
    endcase
  endfunction

  // --------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= st_power;
      wait_reg <= 11'h000;
      sub_reg <= 3'h0;
      acnt_reg <= 3'h0;
      bcnt_reg <= 10'h000;
      op_reg <= 2'h0;
      half_reg <= 1'b0;
      addr_reg <= 27'h0;
      req_ready <= 1'b0;
      wr_take <= 1'b0;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      done <= 1'b0;
      chip_enable_n <= 1'b1;
      cmd_latch <= 1'b0;
      addr_latch <= 1'b0;
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      write_protect_n <= 1'b0;
      io_out <= 8'h00;
      io_oe <= 1'b0;
    end else begin
      wr_take <= 1'b0;
      rd_valid <= 1'b0;
      done <= 1'b0;
      case (state_reg)
        st_power: begin
          wait_reg <= wait_reg + 11'h001;
          if (wait_reg == 11'(powerup_cycles)) begin
            state_reg <= st_idle;
            req_ready <= 1'b1;
            write_protect_n <= 1'b1;
          end
        end
        st_idle: begin
          // op code 3 is refused, so no copy-back or other pairing is ever issued
          if (req_valid && req_ready && req_op != 2'h3) begin
            req_ready <= 1'b0;
            op_reg <= req_op;
            half_reg <= req_second_half;
            addr_reg <= req_addr;
            chip_enable_n <= 1'b0;
            sub_reg <= 3'h0;
            state_reg <= st_cmd;
          end
        end
        st_cmd, st_addr, st_conf, st_data: begin
          sub_reg <= sub_reg + 3'h1;
          if (sub_reg == 3'h0) begin
            io_oe <= 1'b1;
            write_strobe_n <= 1'b0;
            cmd_latch <= (state_reg == st_cmd) || (state_reg == st_conf);
            addr_latch <= (state_reg == st_addr);
            case (state_reg)
              st_cmd: io_out <= (op_reg == 2'h1) ? cmd_program_setup :
                (op_reg == 2'h2) ? cmd_erase_setup :
                (half_reg ? cmd_read_second_half : cmd_read_first_half);
              st_conf: io_out <= (op_reg == 2'h1) ? cmd_program_confirm : cmd_erase_confirm;
              st_addr: io_out <= addr_byte(acnt_reg, addr_reg);
              default: begin
                io_out <= wr_data;
                wr_take <= 1'b1;
              end
            endcase
          end else if (sub_reg == 3'(strobe_cycles)) begin
            write_strobe_n <= 1'b1;
          end else if (sub_reg == 3'(strobe_cycles + 1)) begin
            sub_reg <= 3'h0;
            cmd_latch <= 1'b0;
            addr_latch <= 1'b0;
            io_oe <= 1'b0;
            case (state_reg)
              st_cmd: begin
                acnt_reg <= (op_reg == 2'h2) ? 3'h1 : 3'h0;
                state_reg <= st_addr;
              end
              st_addr: begin
                acnt_reg <= acnt_reg + 3'h1;
                if (acnt_reg == 3'h3) begin
                  bcnt_reg <= 10'h000;
                  state_reg <= (op_reg == 2'h0) ? st_wbusy :
                    (op_reg == 2'h1) ? st_data : st_conf;
                  wait_reg <= 11'h000;
                end
              end
              st_data: begin
                bcnt_reg <= bcnt_reg + 10'h001;
                if (bcnt_reg == 10'(page_bytes - 1)) begin
                  state_reg <= st_conf;
                end
              end
              default: begin
                wait_reg <= 11'h000;
                state_reg <= st_wbusy;
              end
            endcase
          end
        end
        st_wbusy: begin
          // allow busy to assert before trusting ready again
          if (wait_reg < 11'h010) begin
            wait_reg <= wait_reg + 11'h001;
          end else if (rb_reg) begin
            if (op_reg == 2'h0) begin
              state_reg <= st_read;
              sub_reg <= 3'h0;
            end else begin
              done <= 1'b1;
              chip_enable_n <= 1'b1;
              req_ready <= 1'b1;
              state_reg <= st_idle;
            end
          end
        end
        st_read: begin
          sub_reg <= sub_reg + 3'h1;
          if (sub_reg == 3'h0) begin
            read_strobe_n <= 1'b0;
          end else if (sub_reg == 3'(strobe_cycles)) begin
            rd_data <= io_in;
            rd_valid <= 1'b1;
            read_strobe_n <= 1'b1;
          end else if (sub_reg == 3'(strobe_cycles + 1)) begin
            sub_reg <= 3'h0;
            bcnt_reg <= bcnt_reg + 10'h001;
            if (bcnt_reg == 10'(page_bytes - 1) - {1'b0, half_reg, addr_reg[7:0]}) begin
              done <= 1'b1;
              chip_enable_n <= 1'b1;
              req_ready <= 1'b1;
              state_reg <= st_idle;
            end
          end
        end
        default: state_reg <= st_idle;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  a_fourth_addr_high: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == st_addr && io_oe && acnt_reg == 3'h3) |-> io_out[7:2] == 6'h00)
    else $error("fourth address byte has high bits set");
  a_latch_exclusive: assert property (@(posedge clock) disable iff (!rstn)
    !(cmd_latch && addr_latch) && (!io_oe || cmd_latch || addr_latch || state_reg == st_data))
    else $error("port driven without a qualifier");
  a_half_cmd: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == st_cmd && cmd_latch && op_reg == 2'h0) |-> io_out == {7'h00, half_reg})
    else $error("read code does not match half select");
  a_no_cmd_early: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == st_power) |-> write_strobe_n && chip_enable_n)
    else $error("strobe during power-up wait");
  a_strobe_ce: assert property (@(posedge clock) disable iff (!rstn)
    $fell(write_strobe_n) |-> !chip_enable_n ##3 $rose(write_strobe_n))
    else $error("write strobe shape wrong");
  a_read_strobe: assert property (@(posedge clock) disable iff (!rstn)
    $fell(read_strobe_n) |-> ##3 rd_valid)
    else $error("read strobe without data");
  a_busy_wait: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == st_wbusy && !rb_reg) |=> state_reg == st_wbusy)
    else $error("left busy wait while busy");
  a_wp_power: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == st_power) |-> !write_protect_n)
    else $error("write protect released during power-up");
  c_read: cover property (@(posedge clock) disable iff (!rstn)
    state_reg == st_read ##1 done);
  c_program: cover property (@(posedge clock) disable iff (!rstn)
    state_reg == st_wbusy && op_reg == 2'h1 ##1 done);
  c_erase: cover property (@(posedge clock) disable iff (!rstn)
    state_reg == st_wbusy && op_reg == 2'h2 ##1 done);
endmodule

//--- flash_model.sv
// behavioural byte-wide flash answering the nand_host pins
// assumes the host io is split; the bench resolves io_in from this model
`timescale 1ns/1ns
module flash_model #(
  parameter int busy_ns = 3000
) (
  input wire logic chip_enable_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_protect_n,
  input wire logic [7:0] io_out,
  input wire logic io_oe,
  output logic [7:0] io_in,
  output logic ready_busy_n
);
  logic [7:0] cmd_q[$];
  logic [7:0] addr_q[$];
  logic [7:0] data_q[$];
  logic [9:0] col = 10'h000;
  logic [7:0] cur = 8'h00;
  logic half = 1'b0;
  time busy_end = 0;
  int n_lockout = 0;
  int n_float = 0;
  initial ready_busy_n = 1'b1;
  // no pull on io: show the inverse once released
  assign io_in = (!chip_enable_n && !read_strobe_n) ? cur : ~cur;
  task automatic go_busy(input int t);
    ready_busy_n = 1'b0;
    #t;
    ready_busy_n = 1'b1;
    busy_end = $time;
  endtask
  always @(posedge write_strobe_n) begin
    if (!chip_enable_n && !io_oe) n_float++;
    if (!chip_enable_n && cmd_latch) begin
      cmd_q.push_back(io_out);
      if (io_out inside {8'h00, 8'h01, 8'h80, 8'h60}) begin
        addr_q.delete();
        half = io_out[0];
      end
      if (io_out == 8'h10 || io_out == 8'hd0) begin
        if (!write_protect_n) n_lockout++;
        else fork go_busy(busy_ns); join_none
      end
    end else if (!chip_enable_n && addr_latch) begin
      if (addr_q.size() < ((cmd_q[$] == 8'h60) ? 3 : 4)) begin
        addr_q.push_back(io_out);
        if (addr_q.size() == 4 && cmd_q[$] < 8'h02) begin
          col = {half, addr_q[0]};
          fork go_busy(busy_ns / 4); join_none
        end
      end
    end else if (!chip_enable_n) data_q.push_back(io_out);
  end
  always @(negedge read_strobe_n) begin
    if (io_oe) n_float++;
    if (!chip_enable_n) begin
      cur = col[7:0] ^ 8'ha5;
      col++;
    end
  end
endmodule

//--- nand_host_tb.sv
// self-checking bench for nand_host with a behavioural flash
// assumes flash_model.sv and the design package are compiled first
`timescale 1ns/1ns
module nand_host_tb;
  import nand_host_pkg::*;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t got %h want %h", $time, (a), (b)); end end
  logic clock = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_second_half = 1'b0;
  logic [1:0] req_op = 2'h0;
  logic [26:0] req_addr = 27'h0000000;
  logic [7:0] wr_data = 8'h00, rd_data, io_out, io_in;
  logic req_ready, wr_take, rd_valid, done, chip_enable_n, cmd_latch, addr_latch;
  logic write_strobe_n, read_strobe_n, write_protect_n, io_oe, ready_busy_n;
  int err_count = 0, n_compared = 0;
  nand_host i_dut (.clock(clock), .rstn(rstn), .req_valid(req_valid), .req_op(req_op),
    .req_second_half(req_second_half), .req_addr(req_addr), .req_ready(req_ready),
    .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
    .done(done), .chip_enable_n(chip_enable_n), .cmd_latch(cmd_latch),
    .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .write_protect_n(write_protect_n), .io_out(io_out),
    .io_oe(io_oe), .io_in(io_in), .ready_busy_n(ready_busy_n));
  flash_model i_flash (.chip_enable_n(chip_enable_n), .cmd_latch(cmd_latch),
    .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .write_protect_n(write_protect_n),
    .io_out(io_out), .io_oe(io_oe), .io_in(io_in), .ready_busy_n(ready_busy_n));
  initial forever #5 clock = ~clock;
  always @(posedge clock) if (wr_take === 1'b1) wr_data <= wr_data + 8'h01;
  task automatic finish_test();
    if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [7:0] abyte(input logic [26:0] a, input int k);
    case (k)
      0: abyte = a[7:0];
      1: abyte = a[16:9];
      2: abyte = a[24:17];
      default: abyte = {6'h00, a[26:25]};
    endcase
  endfunction
  // ----------------------------------------
  // one operation, checking read bytes as they come
  // ----------------------------------------
  task automatic run_op(input logic [1:0] op, input logic half, input logic [26:0] a,
                        output int nrd);
    int i;
    logic [9:0] c;
    time t0;
    nrd = 0;
    i = 0;
    c = {half, a[7:0]};
    i_flash.cmd_q.delete();
    i_flash.data_q.delete();
    while (req_ready !== 1'b1) begin
      i++;
      if (i > 300) begin err_count++; finish_test(); end
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    req_valid <= 1'b1;
    req_op <= op;
    req_second_half <= half;
    req_addr <= a;
    wr_data <= 8'h00;
    @(posedge clock);
    req_valid <= 1'b0;
    t0 = $time;
    i = 0;
    do begin
      @(posedge clock);
      #1;
      if (rd_valid === 1'b1) begin `CHK(rd_data, c[7:0] ^ 8'ha5) c++; nrd++; end
      i++;
      if (i > 40000) begin err_count++; finish_test(); end
    end while (done !== 1'b1);
    `CHK(i_flash.busy_end > t0, 1'b1)
    `CHK(ready_busy_n, 1'b1)
    `CHK(i_flash.n_float, 0)
    `CHK(i_flash.n_lockout, 0)
  endtask
  task automatic check_addr(input logic [26:0] a, input int first);
    `CHK(i_flash.addr_q.size(), 4 - first)
    for (int k = first; k < 4; k++) `CHK(i_flash.addr_q[k - first], abyte(a, k))
  endtask
  task automatic t_read(input logic half, input logic [26:0] a);
    int n;
    run_op(2'h0, half, a, n);
    `CHK(i_flash.cmd_q[0], {7'h00, half})
    `CHK(n, page_bytes - {half, a[7:0]})
    check_addr(a, 0);
  endtask
  task automatic t_program();
    int n;
    run_op(2'h1, 1'b0, 27'h7fffeff, n);
    `CHK({i_flash.cmd_q[0], i_flash.cmd_q[1]}, 16'h8010)
    `CHK(i_flash.cmd_q.size(), 2)
    `CHK(i_flash.data_q.size(), 528)
    for (int k = 0; k < 528; k++) `CHK(i_flash.data_q[k], k[7:0])
    check_addr(27'h7fffeff, 0);
  endtask
  task automatic t_erase();
    int n;
    run_op(2'h2, 1'b0, 27'h5a5a5ff, n);
    `CHK({i_flash.cmd_q[0], i_flash.cmd_q[1]}, 16'h60d0)
    check_addr(27'h5a5a5ff, 1);
  endtask
  task automatic t_refuse();
    @(posedge clock);
    req_valid <= 1'b1;
    req_op <= 2'h3;
    repeat (3) @(posedge clock);
    req_valid <= 1'b0;
    @(posedge clock);
    #1;
    `CHK({req_ready, chip_enable_n}, 2'b11)
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (powerup_cycles) begin @(posedge clock); #1; `CHK({req_ready, chip_enable_n}, 2'b01) end
    t_read(1'b0, 27'h12345f0);
    t_read(1'b1, 27'h2aaaa0f);
    t_program();
    t_erase();
    t_refuse();
    finish_test();
  end
endmodule
